// file: hdl/tlcu_pkg.sv
// Purpose: Shared constants and carrier types of the time latch capture unit.
// Assumes: Byte-wide register ports with 16-bit byte addresses.
// Notes: Timestamp slots are ordered input A rise, A fall, B rise, B fall.
package tlcu_pkg;

    // Register byte addresses.
    localparam logic [15:0] ADDR_CAPTURE_A_CONTROL = 16'h09a8;
    localparam logic [15:0] ADDR_CAPTURE_B_CONTROL = 16'h09a9;
    localparam logic [15:0] ADDR_CAPTURE_A_STATUS = 16'h09ae;
    localparam logic [15:0] ADDR_CAPTURE_B_STATUS = 16'h09af;
    localparam logic [15:0] ADDR_CAPTURE_A_RISE_TIME = 16'h09b0;
    localparam logic [15:0] ADDR_CAPTURE_A_FALL_TIME = 16'h09b8;
    localparam logic [15:0] ADDR_CAPTURE_B_RISE_TIME = 16'h09c0;
    localparam logic [15:0] ADDR_CAPTURE_B_FALL_TIME = 16'h09c8;
    // Byte span of the four timestamp registers together.
    localparam logic [15:0] TIME_SPAN = 16'h0020;

    // Field positions shared by control and status bytes.
    localparam int CTRL_RISE_SINGLE_BIT = 0;
    localparam int CTRL_FALL_SINGLE_BIT = 1;
    localparam int STAT_RISE_EVENT_BIT = 0;
    localparam int STAT_FALL_EVENT_BIT = 1;
    localparam int STAT_PIN_LEVEL_BIT = 2;
    // Mask of the writable control bits; bits 7:2 stay zero.
    localparam logic [7:0] CTRL_WRITE_MASK = 8'h03;

    // Reset values.
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [63:0] TIME_RESET = 64'h0000_0000_0000_0000;
    localparam logic [7:0] RDATA_RESET = 8'h00;

    // Timestamp slot indices.
    localparam int SLOT_A_RISE = 0;
    localparam int SLOT_A_FALL = 1;
    localparam int SLOT_B_RISE = 2;
    localparam int SLOT_B_FALL = 3;

    // One byte access from either register port.
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } tlcu_req_t;

    // Everything a read port can return.
    typedef struct packed {
        logic [7:0] ctrl_a;
        logic [7:0] ctrl_b;
        logic [7:0] stat_a;
        logic [7:0] stat_b;
        logic [3:0][63:0] times;
    } tlcu_image_t;

endpackage : tlcu_pkg

// file: hdl/tlcu_edge_chan.sv
// Purpose: One capture input: synchroniser, edge detection, timestamps and event flags.
// Assumes: The system time input is stable in the core clock domain.
// Notes: Edge detection starts only once the synchroniser holds real pin samples.
`timescale 1ns/1ns
module tlcu_edge_chan #(
    parameter int TIME_W = 64
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_pin,
    input wire logic [TIME_W-1:0] i_sys_time,
    input wire logic i_rise_single,
    input wire logic i_fall_single,
    input wire logic i_clr_rise,
    input wire logic i_clr_fall,
    output logic [TIME_W-1:0] o_rise_time,
    output logic [TIME_W-1:0] o_fall_time,
    output logic o_rise_flag,
    output logic o_fall_flag,
    output logic o_pin_level
);
    logic meta_reg;
    logic level_reg;
    logic prev_reg;
    logic [1:0] prime_reg;
    logic armed;
    logic rise_edge;
    logic fall_edge;
    logic rise_take;
    logic fall_take;

    // A flag that is being cleared in this cycle may already accept a new edge.
    assign armed = (prime_reg == 2'h3);
    assign rise_edge = armed & level_reg & ~prev_reg;
    assign fall_edge = armed & ~level_reg & prev_reg;
    assign rise_take = rise_edge & (~i_rise_single | ~o_rise_flag | i_clr_rise);
    assign fall_take = fall_edge & (~i_fall_single | ~o_fall_flag | i_clr_fall);
    assign o_pin_level = level_reg;

    // Two-flop synchroniser; the edge logic looks at level_reg and prev_reg, never at meta_reg.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            meta_reg <= 1'b0;
            level_reg <= 1'b0;
            prev_reg <= 1'b0;
            prime_reg <= 2'h0;
        end else if (i_ce) begin
            meta_reg <= i_pin;
            level_reg <= meta_reg;
            prev_reg <= level_reg;
            if (!armed) prime_reg <= prime_reg + 2'h1;
        end
    end

    // Timestamps and single-event flags; a new event wins over a clear.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            o_rise_time <= tlcu_pkg::TIME_RESET;
            o_fall_time <= tlcu_pkg::TIME_RESET;
            o_rise_flag <= 1'b0;
            o_fall_flag <= 1'b0;
        end else if (i_ce) begin
            if (rise_take) o_rise_time <= i_sys_time;
            if (fall_take) o_fall_time <= i_sys_time;
            if (rise_take && i_rise_single) o_rise_flag <= 1'b1;
            else if (i_clr_rise || !i_rise_single) o_rise_flag <= 1'b0;
            if (fall_take && i_fall_single) o_fall_flag <= 1'b1;
            else if (i_clr_fall || !i_fall_single) o_fall_flag <= 1'b0;
        end
    end

endmodule : tlcu_edge_chan

// file: hdl/tlcu_read_port.sv
// Purpose: Read side of one register port, with its own upper-byte snapshots.
// Assumes: One byte access per strobe; read data returns one cycle later.
// Notes: Each port keeps private snapshots so the two ports never disturb each other's upper bytes.
`timescale 1ns/1ns
module tlcu_read_port (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire tlcu_pkg::tlcu_req_t i_req,
    input wire tlcu_pkg::tlcu_image_t i_image,
    output logic [3:0] o_low_read,
    output logic [7:0] o_rdata,
    output logic o_rvalid
);
    logic [3:0][55:0] snap_reg;
    logic [15:0] ts_off;
    logic ts_hit;
    logic [1:0] slot;
    logic [2:0] byte_sel;
    logic [63:0] ts_view;
    logic [7:0] rd_next;

    // Timestamp window decode.
    assign ts_off = i_req.addr - tlcu_pkg::ADDR_CAPTURE_A_RISE_TIME;
    assign ts_hit = (ts_off < tlcu_pkg::TIME_SPAN);
    assign slot = ts_off[4:3];
    assign byte_sel = ts_off[2:0];
    assign o_low_read = (i_req.rd && ts_hit && byte_sel == 3'h0) ? (4'h1 << slot) : 4'h0;
    // Low byte is live, upper bytes come from the snapshot taken at the low-byte read.
    assign ts_view = {snap_reg[slot], i_image.times[slot][7:0]};

    // Read data selection; unmapped addresses in this block read as zero.
    assign rd_next = (i_req.addr == tlcu_pkg::ADDR_CAPTURE_A_CONTROL) ? i_image.ctrl_a :
                     (i_req.addr == tlcu_pkg::ADDR_CAPTURE_B_CONTROL) ? i_image.ctrl_b :
                     (i_req.addr == tlcu_pkg::ADDR_CAPTURE_A_STATUS) ? i_image.stat_a :
                     (i_req.addr == tlcu_pkg::ADDR_CAPTURE_B_STATUS) ? i_image.stat_b :
                     ts_hit ? ts_view[byte_sel*8 +: 8] : tlcu_pkg::RDATA_RESET;

    // Snapshot and registered answer.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            snap_reg <= '0;
            o_rdata <= tlcu_pkg::RDATA_RESET;
            o_rvalid <= 1'b0;
        end else if (i_ce) begin
            for (int k = 0; k < 4; k++) begin
                if (o_low_read[k]) snap_reg[k] <= i_image.times[k][63:8];
            end
            o_rvalid <= i_req.rd;
            if (i_req.rd) o_rdata <= rd_next;
        end
    end

endmodule : tlcu_read_port

// file: hdl/tlcu_top.sv
// Purpose: Time latch capture unit with network-side and host process-data register ports.
// Assumes: Ownership bits and the host write-acknowledge mode arrive as levels from
//          the distributed-clock configuration; system time is in the core clock domain.
// Notes: Both ports read every register; ownership decides who may write and who clears.
`timescale 1ns/1ns

module tlcu_top #(
    parameter int TIME_W = 64
) (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_capture_input_a,
    input wire logic i_capture_input_b,
    input wire logic [TIME_W-1:0] i_sys_time,
    input wire logic i_own_a_host,
    input wire logic i_own_b_host,
    input wire logic i_host_wr_ack_en,
    input wire tlcu_pkg::tlcu_req_t i_net_req,
    input wire tlcu_pkg::tlcu_req_t i_host_req,
    output logic [7:0] o_net_rdata,
    output logic o_net_rvalid,
    output logic [7:0] o_host_rdata,
    output logic o_host_rvalid
);
    // Control registers and their next values.
    logic [7:0] ctrl_a_reg;
    logic [7:0] ctrl_b_reg;
    logic [7:0] ctrl_a_next;
    logic [7:0] ctrl_b_next;

    // Write decode per port.
    logic net_ctrl_a_wr;
    logic net_ctrl_b_wr;
    logic host_ctrl_a_wr;
    logic host_ctrl_b_wr;
    logic [15:0] host_ts_off;
    logic host_ts_wr_hit;
    logic [3:0] host_ts_wr;

    // Read-side low-byte strobes from both ports.
    logic [3:0] net_low_read;
    logic [3:0] host_low_read;

    // Clear requests per timestamp slot.
    logic [3:0] net_clear;
    logic [3:0] host_rd_clear;
    logic [3:0] host_wr_clear;
    logic [3:0] clear_slot;
    logic [3:0] owner_host;

    // Channel outputs.
    logic [TIME_W-1:0] a_rise_time;
    logic [TIME_W-1:0] a_fall_time;
    logic [TIME_W-1:0] b_rise_time;
    logic [TIME_W-1:0] b_fall_time;
    logic a_rise_flag;
    logic a_fall_flag;
    logic b_rise_flag;
    logic b_fall_flag;
    logic a_level;
    logic b_level;

    // Register image shared by both read ports.
    tlcu_pkg::tlcu_image_t image;
    logic [7:0] stat_a;
    logic [7:0] stat_b;

    // Control write decode; a write from the port that does not own the input is dropped.
    assign net_ctrl_a_wr = i_net_req.wr &&
                           (i_net_req.addr == tlcu_pkg::ADDR_CAPTURE_A_CONTROL) &&
                           !i_own_a_host;
    assign host_ctrl_a_wr = i_host_req.wr &&
                            (i_host_req.addr == tlcu_pkg::ADDR_CAPTURE_A_CONTROL) &&
                            i_own_a_host;
    assign net_ctrl_b_wr = i_net_req.wr &&
                           (i_net_req.addr == tlcu_pkg::ADDR_CAPTURE_B_CONTROL) &&
                           !i_own_b_host;
    assign host_ctrl_b_wr = i_host_req.wr &&
                            (i_host_req.addr == tlcu_pkg::ADDR_CAPTURE_B_CONTROL) &&
                            i_own_b_host;

    // Next control values; reserved bits are forced to zero whatever is written.
    always_comb begin
        ctrl_a_next = ctrl_a_reg;
        ctrl_b_next = ctrl_b_reg;
        if (net_ctrl_a_wr) begin
            ctrl_a_next = i_net_req.wdata & tlcu_pkg::CTRL_WRITE_MASK;
        end else if (host_ctrl_a_wr) begin
            ctrl_a_next = i_host_req.wdata & tlcu_pkg::CTRL_WRITE_MASK;
        end
        if (net_ctrl_b_wr) begin
            ctrl_b_next = i_net_req.wdata & tlcu_pkg::CTRL_WRITE_MASK;
        end else if (host_ctrl_b_wr) begin
            ctrl_b_next = i_host_req.wdata & tlcu_pkg::CTRL_WRITE_MASK;
        end
    end

    // Control registers; only ownership-permitted writes reach them.
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ctrl_a_reg <= tlcu_pkg::CTRL_RESET;
            ctrl_b_reg <= tlcu_pkg::CTRL_RESET;
        end else if (i_ce) begin
            ctrl_a_reg <= ctrl_a_next;
            ctrl_b_reg <= ctrl_b_next;
        end
    end

    // Ownership per slot: slots 0 and 1 belong to input A, slots 2 and 3 to input B.
    assign owner_host = {i_own_b_host, i_own_b_host, i_own_a_host, i_own_a_host};

    // Host writes into the timestamp window act only as acknowledges.
    // Network-side writes to the window are not decoded at all, so they vanish.
    assign host_ts_off = i_host_req.addr - tlcu_pkg::ADDR_CAPTURE_A_RISE_TIME;
    assign host_ts_wr_hit = i_host_req.wr && (host_ts_off < tlcu_pkg::TIME_SPAN);
    assign host_ts_wr = host_ts_wr_hit ? (4'h1 << host_ts_off[4:3]) : 4'h0;

    // Clear sources. The network side clears when it owns the input. The host clears by
    // reading when acknowledge-by-write is off, and by writing any byte when it is on.
    // Clearing on the low byte read keeps one clear per timestamp read-out sequence.
    assign net_clear = net_low_read & ~owner_host;
    assign host_rd_clear = host_low_read & owner_host &
                           {4{~i_host_wr_ack_en}};
    assign host_wr_clear = host_ts_wr & owner_host &
                           {4{i_host_wr_ack_en}};
    assign clear_slot = net_clear | host_rd_clear | host_wr_clear;

    // Capture input A: pin synchroniser, edge capture and single-event flags.
    tlcu_edge_chan #(
        .TIME_W(TIME_W)
    ) u_chan_a (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_pin(i_capture_input_a),
        .i_sys_time(i_sys_time),
        .i_rise_single(ctrl_a_reg[tlcu_pkg::CTRL_RISE_SINGLE_BIT]),
        .i_fall_single(ctrl_a_reg[tlcu_pkg::CTRL_FALL_SINGLE_BIT]),
        .i_clr_rise(clear_slot[tlcu_pkg::SLOT_A_RISE]),
        .i_clr_fall(clear_slot[tlcu_pkg::SLOT_A_FALL]),
        .o_rise_time(a_rise_time),
        .o_fall_time(a_fall_time),
        .o_rise_flag(a_rise_flag),
        .o_fall_flag(a_fall_flag),
        .o_pin_level(a_level)
    );

    // Capture input B uses the same channel with its own control byte.
    tlcu_edge_chan #(
        .TIME_W(TIME_W)
    ) u_chan_b (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_pin(i_capture_input_b),
        .i_sys_time(i_sys_time),
        .i_rise_single(ctrl_b_reg[tlcu_pkg::CTRL_RISE_SINGLE_BIT]),
        .i_fall_single(ctrl_b_reg[tlcu_pkg::CTRL_FALL_SINGLE_BIT]),
        .i_clr_rise(clear_slot[tlcu_pkg::SLOT_B_RISE]),
        .i_clr_fall(clear_slot[tlcu_pkg::SLOT_B_FALL]),
        .o_rise_time(b_rise_time),
        .o_fall_time(b_fall_time),
        .o_rise_flag(b_rise_flag),
        .o_fall_flag(b_fall_flag),
        .o_pin_level(b_level)
    );

    // Status bytes: event flags, live pin level and zeros in the reserved bits.
    always_comb begin
        stat_a = 8'h00;
        stat_a[tlcu_pkg::STAT_RISE_EVENT_BIT] = a_rise_flag;
        stat_a[tlcu_pkg::STAT_FALL_EVENT_BIT] = a_fall_flag;
        stat_a[tlcu_pkg::STAT_PIN_LEVEL_BIT] = a_level;
        stat_b = 8'h00;
        stat_b[tlcu_pkg::STAT_RISE_EVENT_BIT] = b_rise_flag;
        stat_b[tlcu_pkg::STAT_FALL_EVENT_BIT] = b_fall_flag;
        stat_b[tlcu_pkg::STAT_PIN_LEVEL_BIT] = b_level;
    end

    // Gather the readable state into one image for both read ports.
    assign image.ctrl_a = ctrl_a_reg;
    assign image.ctrl_b = ctrl_b_reg;
    assign image.stat_a = stat_a;
    assign image.stat_b = stat_b;
    assign image.times[tlcu_pkg::SLOT_A_RISE] = 64'(a_rise_time);
    assign image.times[tlcu_pkg::SLOT_A_FALL] = 64'(a_fall_time);
    assign image.times[tlcu_pkg::SLOT_B_RISE] = 64'(b_rise_time);
    assign image.times[tlcu_pkg::SLOT_B_FALL] = 64'(b_fall_time);

    // Network-side read port with private snapshots.
    tlcu_read_port u_net_port (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_req(i_net_req),
        .i_image(image),
        .o_low_read(net_low_read),
        .o_rdata(o_net_rdata),
        .o_rvalid(o_net_rvalid)
    );

    // Host process-data read port; its snapshots are independent of the network side.
    tlcu_read_port u_host_port (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_ce(i_ce),
        .i_req(i_host_req),
        .i_image(image),
        .o_low_read(host_low_read),
        .o_rdata(o_host_rdata),
        .o_rvalid(o_host_rvalid)
    );

endmodule : tlcu_top

// file: test/tlcu_properties.sv
// Purpose: Port assertions for the capture unit register ports and pins.
// Assumes: One core clock; reset is synchronous and active high.
// Notes: Attached to tlcu_top by the bind at the foot of this file.
`timescale 1ns/1ns
module tlcu_properties (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    input wire logic i_capture_input_b,
    input wire logic i_own_b_host,
    input wire tlcu_pkg::tlcu_req_t i_net_req,
    input wire tlcu_pkg::tlcu_req_t i_host_req,
    input wire logic [7:0] o_net_rdata,
    input wire logic o_net_rvalid,
    input wire logic [7:0] o_host_rdata,
    input wire logic o_host_rvalid
);
    // Accepted read strobes; a frozen clock enable takes nothing.
    wire net_rd = i_ce && i_net_req.rd;
    wire host_rd = i_ce && i_host_req.rd;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    AST_NET_RVALID: assert property (net_rd |=> o_net_rvalid)
        else $error("net read got no answer");
    AST_NET_IDLE: assert property (i_ce && !i_net_req.rd |=> !o_net_rvalid)
        else $error("net answer without a read");
    AST_HOST_RVALID: assert property (host_rd |=> o_host_rvalid)
        else $error("host read got no answer");
    AST_RESET_ZERO: assert property (disable iff (1'b0) i_reset && i_ce |=>
        !o_net_rvalid && !o_host_rvalid && o_net_rdata == 8'h00 && o_host_rdata == 8'h00)
        else $error("read ports not cleared by reset");
    AST_CTRL_RSVD: assert property (net_rd &&
        i_net_req.addr == tlcu_pkg::ADDR_CAPTURE_B_CONTROL |=> o_net_rdata[7:2] == 6'h00)
        else $error("control reserved bits not zero");
    AST_STAT_RSVD: assert property (host_rd &&
        i_host_req.addr == tlcu_pkg::ADDR_CAPTURE_B_STATUS |=> o_host_rdata[7:3] == 5'h00)
        else $error("status reserved bits not zero");
    // Owner write, one quiet cycle, then a read must show the masked value.
    AST_CTRL_WRITE: assert property (i_ce && i_net_req.wr && !i_own_b_host &&
        i_net_req.addr == tlcu_pkg::ADDR_CAPTURE_B_CONTROL ##1
        i_ce && !i_net_req.wr && !i_host_req.wr ##1
        net_rd && i_net_req.addr == tlcu_pkg::ADDR_CAPTURE_B_CONTROL
        |=> o_net_rdata == ($past(i_net_req.wdata, 3) & 8'h03))
        else $error("owner control write not seen");
    // The level bit needs a pin held long enough to pass the synchroniser.
    AST_PIN_LEVEL: assert property ((i_ce && $stable(i_capture_input_b)) [*5] ##0
        (net_rd && i_net_req.addr == tlcu_pkg::ADDR_CAPTURE_B_STATUS)
        |=> o_net_rdata[2] == $past(i_capture_input_b))
        else $error("pin level bit wrong");

    COV_NET_TIME: cover property (net_rd && i_net_req.addr == tlcu_pkg::ADDR_CAPTURE_B_RISE_TIME);
    COV_HOST_ACK: cover property (i_host_req.wr && i_host_req.addr[15:4] == 12'h09b);
    COV_PIN_RISE: cover property ($rose(i_capture_input_b));
endmodule : tlcu_properties

bind tlcu_top tlcu_properties i_tlcu_properties (
    .i_clk, .i_reset, .i_ce, .i_capture_input_b, .i_own_b_host, .i_net_req,
    .i_host_req, .o_net_rdata, .o_net_rvalid, .o_host_rdata, .o_host_rvalid
);

// file: test/tlcu_pin_source.sv
// Purpose: External signal source for the two capture pins.
// Assumes: Levels change just after a rising clock edge.
// Notes: Every level is held four cycles, so short glitches are never made.
`timescale 1ns/1ns
module tlcu_pin_source (
    input wire logic i_clk,
    output logic o_pin_a,
    output logic o_pin_b
);
    // Both pins idle low from time zero.
    initial begin
        o_pin_a = 1'b0;
        o_pin_b = 1'b0;
    end

    // Longer than the two-cycle minimum, so the synchroniser always sees it.
    task automatic drive(input logic sel_b, input logic level);
        @(posedge i_clk);
        #1;
        if (sel_b) begin
            o_pin_b = level;
        end else begin
            o_pin_a = level;
        end
        repeat (4) @(posedge i_clk);
    endtask : drive
endmodule : tlcu_pin_source

// file: test/test_tlcu_top.sv
// Purpose: Self-checking bench for the capture unit through both register ports.
// Assumes: Input A owned by the host port until the last scenario, input B by the network side.
// Notes: System time steps in both halves so upper bytes change every cycle.
`timescale 1ns/1ns
module test_tlcu_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic pin_a;
    logic pin_b;
    logic [63:0] sys_time = 64'h0000_0000_0000_0000;
    logic own_a = 1'b1;
    logic own_b = 1'b0;
    logic ack_en = 1'b0;
    tlcu_pkg::tlcu_req_t net_req = '0;
    tlcu_pkg::tlcu_req_t host_req = '0;
    logic [7:0] net_rdata;
    logic net_rvalid;
    logic [7:0] host_rdata;
    logic host_rvalid;
    int err_total = 0;
    int total_checks = 0;
    logic [63:0] t_lo, t_hi, tv, tw, lo1, hi1;
    logic [7:0] rb;

    tlcu_top i_tlcu_top (.i_clk(clk), .i_reset(rst), .i_ce(ce), .i_capture_input_a(pin_a),
        .i_capture_input_b(pin_b), .i_sys_time(sys_time), .i_own_a_host(own_a),
        .i_own_b_host(own_b), .i_host_wr_ack_en(ack_en), .i_net_req(net_req),
        .i_host_req(host_req), .o_net_rdata(net_rdata), .o_net_rvalid(net_rvalid),
        .o_host_rdata(host_rdata), .o_host_rvalid(host_rvalid));
    tlcu_pin_source i_tlcu_pin_source (.i_clk(clk), .o_pin_a(pin_a), .o_pin_b(pin_b));

    // Clock and a system time that moves off the sampling edge.
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        #1;
        sys_time = sys_time + 64'h0000_0001_0000_0001;
    end

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // One byte access; a read answers exactly one cycle later.
    task automatic acc(input logic host, input logic wr, input logic [15:0] a,
        input logic [7:0] d);
        tlcu_pkg::tlcu_req_t q;
        q = '{rd: !wr, wr: wr, addr: a, wdata: d};
        @(posedge clk);
        #1;
        if (host) host_req = q; else net_req = q;
        @(posedge clk);
        #1;
        if (host) host_req = '0; else net_req = '0;
        rb = host ? host_rdata : net_rdata;
        if (!wr) check(host ? host_rvalid : net_rvalid, 1'b1);
    endtask : acc

    // Whole timestamp, low byte first so the upper bytes are consistent.
    task automatic rt(input logic host, input logic [15:0] a);
        for (int i = 0; i < 8; i++) begin
            acc(host, 1'b0, a + 16'(i), 8'h00);
            tv[8*i +: 8] = rb;
        end
    endtask : rt

    task automatic st(input logic [15:0] a, input logic [7:0] exp);
        acc(1'b0, 1'b0, a, 8'h00);
        check(rb, exp);
    endtask : st

    task automatic pin(input logic sel_b, input logic level);
        t_lo = sys_time;
        i_tlcu_pin_source.drive(sel_b, level);
        t_hi = sys_time;
    endtask : pin

    function automatic logic inwin(input logic [63:0] ts);
        return ts >= t_lo && ts <= t_hi;
    endfunction : inwin

    task automatic s_reset();
        logic [15:0] a[6] = '{tlcu_pkg::ADDR_CAPTURE_A_CONTROL,
            tlcu_pkg::ADDR_CAPTURE_B_CONTROL, tlcu_pkg::ADDR_CAPTURE_A_STATUS,
            tlcu_pkg::ADDR_CAPTURE_B_STATUS, 16'h09aa, 16'h09d0};
        foreach (a[i]) begin
            acc(1'b1, 1'b0, a[i], 8'h00);
            check(rb, 8'h00);
        end
        for (int j = 0; j < 4; j++) begin
            rt(1'(j), tlcu_pkg::ADDR_CAPTURE_A_RISE_TIME + 16'(8 * j));
            check(tv, 64'h0);
        end
    endtask : s_reset

    task automatic s_own();
        acc(1'b1, 1'b1, tlcu_pkg::ADDR_CAPTURE_B_CONTROL, 8'h03);
        st(tlcu_pkg::ADDR_CAPTURE_B_CONTROL, 8'h00);
        acc(1'b0, 1'b1, tlcu_pkg::ADDR_CAPTURE_B_CONTROL, 8'hff);
        st(tlcu_pkg::ADDR_CAPTURE_B_CONTROL, 8'h03);
        acc(1'b0, 1'b1, tlcu_pkg::ADDR_CAPTURE_A_CONTROL, 8'h03);
        st(tlcu_pkg::ADDR_CAPTURE_A_CONTROL, 8'h00);
        acc(1'b1, 1'b1, tlcu_pkg::ADDR_CAPTURE_A_CONTROL, 8'h03);
        st(tlcu_pkg::ADDR_CAPTURE_A_CONTROL, 8'h03);
    endtask : s_own

    // Single-event input B; host reads never clear while the network side owns it.
    task automatic s_single_b();
        pin(1'b1, 1'b1);
        rt(1'b1, tlcu_pkg::ADDR_CAPTURE_B_RISE_TIME);
        check(inwin(tv), 1'b1);
        tw = tv;
        st(tlcu_pkg::ADDR_CAPTURE_B_STATUS, 8'h05);
        pin(1'b1, 1'b0);
        rt(1'b1, tlcu_pkg::ADDR_CAPTURE_B_FALL_TIME);
        check(inwin(tv), 1'b1);
        st(tlcu_pkg::ADDR_CAPTURE_B_STATUS, 8'h03);
        pin(1'b1, 1'b1);
        rt(1'b1, tlcu_pkg::ADDR_CAPTURE_B_RISE_TIME);
        check(tv, tw);
        st(tlcu_pkg::ADDR_CAPTURE_B_STATUS, 8'h07);
        rt(1'b0, tlcu_pkg::ADDR_CAPTURE_B_RISE_TIME);
        st(tlcu_pkg::ADDR_CAPTURE_B_STATUS, 8'h06);
        rt(1'b0, tlcu_pkg::ADDR_CAPTURE_B_FALL_TIME);
        st(tlcu_pkg::ADDR_CAPTURE_B_STATUS, 8'h04);
    endtask : s_single_b

    task automatic s_cont_a();
        acc(1'b1, 1'b1, tlcu_pkg::ADDR_CAPTURE_A_CONTROL, 8'h00);
        for (int k = 0; k < 2; k++) begin
            pin(1'b0, 1'b1);
            rt(1'b1, tlcu_pkg::ADDR_CAPTURE_A_RISE_TIME);
            check(inwin(tv), 1'b1);
            st(tlcu_pkg::ADDR_CAPTURE_A_STATUS, 8'h04);
            pin(1'b0, 1'b0);
            rt(1'b1, tlcu_pkg::ADDR_CAPTURE_A_FALL_TIME);
            check(inwin(tv), 1'b1);
            st(tlcu_pkg::ADDR_CAPTURE_A_STATUS, 8'h00);
        end
    endtask : s_cont_a

    // Host-owned input A: read clearing, then acknowledge by write.
    task automatic s_ack_a();
        acc(1'b1, 1'b1, tlcu_pkg::ADDR_CAPTURE_A_CONTROL, 8'h03);
        pin(1'b0, 1'b1);
        acc(1'b1, 1'b1, tlcu_pkg::ADDR_CAPTURE_A_RISE_TIME, 8'h00);
        acc(1'b0, 1'b1, tlcu_pkg::ADDR_CAPTURE_A_RISE_TIME, 8'hff);
        rt(1'b0, tlcu_pkg::ADDR_CAPTURE_A_RISE_TIME);
        check(inwin(tv), 1'b1);
        st(tlcu_pkg::ADDR_CAPTURE_A_STATUS, 8'h05);
        rt(1'b1, tlcu_pkg::ADDR_CAPTURE_A_RISE_TIME);
        st(tlcu_pkg::ADDR_CAPTURE_A_STATUS, 8'h04);
        @(posedge clk);
        #1;
        ack_en = 1'b1;
        pin(1'b0, 1'b0);
        rt(1'b1, tlcu_pkg::ADDR_CAPTURE_A_FALL_TIME);
        st(tlcu_pkg::ADDR_CAPTURE_A_STATUS, 8'h02);
        acc(1'b1, 1'b1, tlcu_pkg::ADDR_CAPTURE_A_FALL_TIME, 8'h00);
        st(tlcu_pkg::ADDR_CAPTURE_A_STATUS, 8'h00);
        rt(1'b1, tlcu_pkg::ADDR_CAPTURE_A_FALL_TIME);
        check(inwin(tv), 1'b1);
    endtask : s_ack_a

    // A low-byte read freezes that port's upper bytes across a new capture.
    task automatic s_snap();
        acc(1'b0, 1'b1, tlcu_pkg::ADDR_CAPTURE_B_CONTROL, 8'h00);
        pin(1'b1, 1'b0);
        lo1 = t_lo;
        hi1 = t_hi;
        acc(1'b0, 1'b0, tlcu_pkg::ADDR_CAPTURE_B_FALL_TIME, 8'h00);
        tw[7:0] = rb;
        pin(1'b1, 1'b1);
        pin(1'b1, 1'b0);
        for (int i = 1; i < 8; i++) begin
            acc(1'b0, 1'b0, tlcu_pkg::ADDR_CAPTURE_B_FALL_TIME + 16'(i), 8'h00);
            tw[8*i +: 8] = rb;
        end
        check(tw >= lo1 && tw <= hi1, 1'b1);
        rt(1'b1, tlcu_pkg::ADDR_CAPTURE_B_FALL_TIME);
        check(inwin(tv), 1'b1);
    endtask : s_snap

    // A frozen clock enable must swallow a read strobe without answering.
    task automatic s_freeze();
        @(posedge clk);
        #1;
        ce = 1'b0;
        net_req = '{rd: 1'b1, wr: 1'b0, addr: tlcu_pkg::ADDR_CAPTURE_B_STATUS, wdata: 8'h00};
        repeat (2) @(posedge clk);
        #1;
        check(net_rvalid, 1'b0);
        net_req = '0;
        ce = 1'b1;
    endtask : s_freeze

    // Network-owned input A: a host read leaves the flag, a network-side read clears it.
    task automatic s_net_a();
        @(posedge clk);
        #1;
        own_a = 1'b0;
        ack_en = 1'b0;
        pin(1'b0, 1'b1);
        rt(1'b1, tlcu_pkg::ADDR_CAPTURE_A_RISE_TIME);
        st(tlcu_pkg::ADDR_CAPTURE_A_STATUS, 8'h05);
        rt(1'b0, tlcu_pkg::ADDR_CAPTURE_A_RISE_TIME);
        check(inwin(tv), 1'b1);
        st(tlcu_pkg::ADDR_CAPTURE_A_STATUS, 8'h04);
    endtask : s_net_a

    task automatic end_sim();
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_sim

    // Main sequence after ten cycles of reset.
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst = 1'b0;
        s_reset();
        s_own();
        s_single_b();
        s_cont_a();
        s_ack_a();
        s_snap();
        s_freeze();
        s_net_a();
        end_sim();
    end

    // Bounds the whole run in case the design hangs.
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        end_sim();
    end
endmodule : test_tlcu_top
